//--- core/diam_map.vh
// constants for the drive i/o image mapper: image numbers, byte positions,
// bit positions, lengths and fifo geometry.
// assumes inclusion by bare name from core/ design files.
`ifndef DIAM_MAP_VH
`define DIAM_MAP_VH

// image numbers
`define DIAM_IMG_OUT_BASIC    8'h14
`define DIAM_IMG_OUT_PARAM    8'h78
`define DIAM_IMG_IN_BASIC     8'h46

// image lengths in bytes
`define DIAM_LEN_BASIC        5'h04
`define DIAM_LEN_PARAM        5'h18
`define DIAM_LEN_IN           5'h04

// byte positions
`define DIAM_BYTE_CTRL        5'h00
`define DIAM_BYTE_SPD_LO      5'h02
`define DIAM_BYTE_SPD_HI      5'h03
`define DIAM_BYTE_PAR_FIRST   5'h04
`define DIAM_PAR_WORDS        4'ha

// bit positions in byte 0
`define DIAM_BIT_RUN_FWD      0
`define DIAM_BIT_FAULT_RST    2
`define DIAM_BIT_FAULTED      0
`define DIAM_BIT_RUNNING_FWD  2

// connections and fifo
`define DIAM_NUM_CONN         2
`define DIAM_FIFO_DEPTH       32
`define DIAM_FIFO_AW          5
`define DIAM_FIFO_WIDTH       8

// reset values
`define DIAM_RST_WORD         16'h0000

`endif

//--- core/diam_fifo.v
// fifo of WIDTH-bit entries with valid/ready on both sides, flip-flop storage.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module diam_fifo
#(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
)
(
    input  wire             core_clk,
    input  wire             sys_rst,
    input  wire [WIDTH-1:0] wr_data,
    input  wire             wr_valid,
    output wire             wr_ready,
    output wire [WIDTH-1:0] rd_data,
    output wire             rd_valid,
    input  wire             rd_ready
);

    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0]    wptr_ff;
    reg [AW-1:0]    rptr_ff;
    reg [AW:0]      cnt_ff;
    wire            do_wr;
    wire            do_rd;

    // honest full/empty from the occupancy count
    assign wr_ready = (cnt_ff != DEPTH[AW:0]);
    assign rd_valid = (cnt_ff != {(AW+1){1'b0}});
    assign rd_data  = mem_ff[rptr_ff];
    assign do_wr    = wr_valid & wr_ready;
    assign do_rd    = rd_valid & rd_ready;

    // storage write, no reset needed on data
    always @(posedge core_clk)
    begin
        if (do_wr)
        begin
            mem_ff[wptr_ff] <= wr_data;
        end
    end

    // pointers and count
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            wptr_ff <= {AW{1'b0}};
            rptr_ff <= {AW{1'b0}};
            cnt_ff  <= {(AW+1){1'b0}};
        end
        else
        begin
            if (do_wr)
            begin
                wptr_ff <= wptr_ff + 1'b1;
            end
            if (do_rd)
            begin
                rptr_ff <= rptr_ff + 1'b1;
            end
            if (do_wr & ~do_rd)
            begin
                cnt_ff <= cnt_ff + 1'b1;
            end
            else if (do_rd & ~do_wr)
            begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

//--- core/diam_mapper.v
// drive i/o image mapper: unpacks output images (client to drive) from a
// byte stream, and packs the input image (drive to client) on request.
// assumes the network stack delivers whole images as byte streams tagged
// with a connection index and image number; one clock, sync reset.
`timescale 1ns/10ps
`default_nettype none
`include "diam_map.vh"

// Functional notes
// - Device only answers images of client-opened connections, never originates.
// - Two connections are served, each with its own stored set; the last image of either drives the outputs.
// - Field positions are fixed per image number; no runtime layout change.
// - One image per connection gathers fields from several drive objects.
// - Output byte 0 bit 0 is run forward, bit 2 fault reset.
// - Speed reference sits in bytes 2 and 3, low byte first.
// - Input byte 0 bit 0 reports faulted, bit 2 running forward.
// - Actual speed is placed in input bytes 2 and 3, low first.
// - Image 120 repeats image 20 then parameter words, low byte first.
// - Image 120 holds ten parameter words, twenty-four bytes in total.
// - Speed words are signed; negative selects reverse rotation.
module diam_mapper
(
    input  wire        core_clk,
    input  wire        sys_rst,
    // output image byte stream from the network side
    input  wire [7:0]  rx_data,
    input  wire        rx_valid,
    input  wire        rx_first,
    input  wire [7:0]  rx_image,
    input  wire        rx_conn,
    output wire        rx_ready,
    // drive command side
    output reg         cmd_run_fwd_ff,
    output reg         cmd_fault_rst_ff,
    output reg  [15:0] cmd_speed_ref_ff,
    output reg         cmd_reverse_ff,
    output reg  [159:0] cmd_param_ff,
    output reg         cmd_update_ff,
    output reg         cmd_conn_ff,
    output reg         rx_error_ff,
    // drive status side
    input  wire        sts_faulted,
    input  wire        sts_running_fwd,
    input  wire [15:0] sts_speed_act,
    // input image request and byte stream to the network side
    input  wire        tx_req,
    output wire        tx_busy,
    output wire [7:0]  tx_data,
    output wire        tx_valid,
    output wire        tx_last,
    input  wire        tx_ready
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // image length per number; zero means unsupported
    function [4:0] img_len;
        input [7:0] num;
        begin
            if (num == `DIAM_IMG_OUT_BASIC)
                img_len = `DIAM_LEN_BASIC;
            else if (num == `DIAM_IMG_OUT_PARAM)
                img_len = `DIAM_LEN_PARAM;
            else
                img_len = 5'h00;
        end
    endfunction

    // ------------------------------------------------------------------
    // receive fifo and output image unpacking
    // ------------------------------------------------------------------
    wire [7:0] f_data;
    wire       f_valid;
    wire       f_ready;
    wire       f_first;
    wire [7:0] f_image;
    wire       f_conn;

    // first flag, image and connection travel with each byte
    diam_fifo #(
        .WIDTH (18),
        .DEPTH (`DIAM_FIFO_DEPTH),
        .AW    (`DIAM_FIFO_AW)
    ) u_rx_fifo (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .wr_data  ({rx_conn, rx_first, rx_image, rx_data}),
        .wr_valid (rx_valid),
        .wr_ready (rx_ready),
        .rd_data  ({f_conn, f_first, f_image, f_data}),
        .rd_valid (f_valid),
        .rd_ready (f_ready)
    );

    reg [4:0]   idx_ff;
    reg [4:0]   len_ff;
    reg         conn_ff;
    reg         stg_run_ff;
    reg         stg_rst_ff;
    reg [15:0]  stg_spd_ff;
    reg [159:0] stg_par_ff;
    reg         par_img_ff;
    // per-connection command sets
    reg         run_ff   [0:1];
    reg         frst_ff  [0:1];
    reg [15:0]  spd_ff   [0:1];

    assign f_ready = 1'b1;
    wire       take     = f_valid;
    wire [4:0] cur_idx  = f_first ? 5'h00 : idx_ff;
    wire [4:0] cur_len  = f_first ? img_len(f_image) : len_ff;
    wire       in_img   = (cur_len != 5'h00) && (cur_idx < cur_len);
    wire       img_done = take && in_img && (cur_idx == cur_len - 5'h01);
    wire [3:0] pword    = cur_idx[4:1] - 4'h2;

    // staging capture; fields commit only once the image is whole
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            idx_ff     <= 5'h00;
            len_ff     <= 5'h00;
            conn_ff    <= 1'b0;
            stg_run_ff <= 1'b0;
            stg_rst_ff <= 1'b0;
            stg_spd_ff <= `DIAM_RST_WORD;
            stg_par_ff <= 160'h0;
            par_img_ff <= 1'b0;
            rx_error_ff <= 1'b0;
        end
        else if (take)
        begin
            rx_error_ff <= f_first && (img_len(f_image) == 5'h00);
            if (f_first)
            begin
                len_ff     <= img_len(f_image);
                conn_ff    <= f_conn;
                par_img_ff <= (f_image == `DIAM_IMG_OUT_PARAM);
            end
            if (in_img)
            begin
                idx_ff <= cur_idx + 5'h01;
                case (cur_idx)
                    `DIAM_BYTE_CTRL:
                    begin
                        // other bits of byte 0 and byte 1 are ignored
                        stg_run_ff <= f_data[`DIAM_BIT_RUN_FWD];
                        stg_rst_ff <= f_data[`DIAM_BIT_FAULT_RST];
                    end
                    `DIAM_BYTE_SPD_LO: stg_spd_ff[7:0]  <= f_data;
                    `DIAM_BYTE_SPD_HI: stg_spd_ff[15:8] <= f_data;
                    default:
                    begin
                        if (cur_idx >= `DIAM_BYTE_PAR_FIRST)
                        begin
                            // word n at bytes 2n+4, 2n+5, low first
                            stg_par_ff[{pword, cur_idx[0], 3'b000} +: 8]
                                <= f_data;
                        end
                    end
                endcase
            end
            else
            begin
                idx_ff <= cur_idx; // surplus bytes dropped
            end
        end
        else
        begin
            // idle cycle ends the error pulse, keeping it one cycle wide
            rx_error_ff <= 1'b0;
        end
    end

    // commit to the drive, one connection's set per image
    integer i;
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            for (i = 0; i < `DIAM_NUM_CONN; i = i + 1)
            begin
                run_ff[i]  <= 1'b0;
                frst_ff[i] <= 1'b0;
                spd_ff[i]  <= `DIAM_RST_WORD;
            end
            cmd_run_fwd_ff   <= 1'b0;
            cmd_fault_rst_ff <= 1'b0;
            cmd_speed_ref_ff <= `DIAM_RST_WORD;
            cmd_reverse_ff   <= 1'b0;
            cmd_param_ff     <= 160'h0;
            cmd_update_ff    <= 1'b0;
            cmd_conn_ff      <= 1'b0;
        end
        else
        begin
            cmd_update_ff <= img_done;
            if (img_done)
            begin
                // each connection keeps its own set; last image drives
                run_ff[conn_ff]  <= stg_run_ff;
                frst_ff[conn_ff] <= stg_rst_ff;
                spd_ff[conn_ff]  <= {f_data, stg_spd_ff[7:0]};
                cmd_conn_ff      <= conn_ff;
                cmd_run_fwd_ff   <= stg_run_ff;
                cmd_fault_rst_ff <= stg_rst_ff;
                // basic image ends on the speed high byte
                if (par_img_ff)
                begin
                    cmd_speed_ref_ff <= stg_spd_ff;
                    cmd_reverse_ff   <= stg_spd_ff[15];
                    cmd_param_ff     <= {f_data, stg_par_ff[151:0]};
                end
                else
                begin
                    cmd_speed_ref_ff <= {f_data, stg_spd_ff[7:0]};
                    cmd_reverse_ff   <= f_data[7];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // input image packing, sent only on a request from the network
    // ------------------------------------------------------------------
    reg [31:0] img_ff;
    reg [1:0]  tcnt_ff;
    reg        tbusy_ff;

    assign tx_busy  = tbusy_ff;
    assign tx_valid = tbusy_ff;
    assign tx_data  = img_ff[{tcnt_ff, 3'b000} +: 8];
    assign tx_last  = tbusy_ff && (tcnt_ff == 2'h3);

    // snapshot taken at the request so the image is coherent
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            img_ff   <= 32'h0000_0000;
            tcnt_ff  <= 2'h0;
            tbusy_ff <= 1'b0;
        end
        else if (!tbusy_ff)
        begin
            if (tx_req)
            begin
                tbusy_ff <= 1'b1;
                tcnt_ff  <= 2'h0;
                img_ff   <= 32'h0000_0000;
                img_ff[`DIAM_BIT_FAULTED]     <= sts_faulted;
                img_ff[`DIAM_BIT_RUNNING_FWD] <= sts_running_fwd;
                img_ff[31:16] <= sts_speed_act;
            end
        end
        else if (tx_ready)
        begin
            tcnt_ff <= tcnt_ff + 2'h1;
            if (tcnt_ff == 2'h3)
            begin
                tbusy_ff <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

//--- test/diam_props_properties.sv
// port checker for the drive i/o image mapper
// assumes a bind onto diam_mapper, one clock, sync reset
`timescale 1ns/10ps
`default_nettype none
module diam_props
(
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        tx_req,
    input wire logic        tx_busy,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_valid,
    input wire logic        tx_last,
    input wire logic        tx_ready,
    input wire logic [15:0] cmd_speed_ref_ff,
    input wire logic        cmd_reverse_ff,
    input wire logic        cmd_update_ff,
    input wire logic        rx_error_ff
);
    // ------------------------------------------------
    // byte position of the outgoing input image
    // ------------------------------------------------
    logic [1:0] idx_ff;
    // wraps after byte 3, so back-to-back images line up
    always @(posedge core_clk)
    begin
        if (sys_rst || !tx_valid)
            idx_ff <= 2'h0;
        else if (tx_ready)
            idx_ff <= idx_ff + 2'h1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    valid_busy_a: assert property (tx_valid == tx_busy)
        else $error("tx valid differs from busy");
    req_start_a: assert property (tx_req && !tx_busy |=> tx_valid)
        else $error("input image not started");
    hold_byte_a: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_data)) else $error("byte dropped");
    last_pos_a: assert property (tx_valid |->
        tx_last == (idx_ff == 2'h3)) else $error("last flag misplaced");
    flag_zero_a: assert property (tx_valid && idx_ff == 2'h0 |->
        tx_data[7:3] == 5'h0 && !tx_data[1]) else $error("stray bits");
    pad_zero_a: assert property (tx_valid && idx_ff == 2'h1 |->
        tx_data == 8'h00) else $error("byte 1 not zero");
    sign_rev_a: assert property (cmd_reverse_ff == cmd_speed_ref_ff[15])
        else $error("reverse differs from sign");
    upd_pulse_a: assert property (cmd_update_ff |=> !cmd_update_ff)
        else $error("update longer than a cycle");
    ref_commit_a: assert property ($changed(cmd_speed_ref_ff) |->
        cmd_update_ff || $past(cmd_update_ff)) else $error("ref moved");
    err_pulse_a: assert property (rx_error_ff |=> !rx_error_ff)
        else $error("error longer than a cycle");
endmodule
bind diam_mapper diam_props u_props (.core_clk(core_clk), .sys_rst(sys_rst),
    .tx_req(tx_req), .tx_busy(tx_busy), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
    .cmd_speed_ref_ff(cmd_speed_ref_ff), .cmd_reverse_ff(cmd_reverse_ff),
    .cmd_update_ff(cmd_update_ff), .rx_error_ff(rx_error_ff));
`default_nettype wire

//--- test/diam_client.sv
// client model: takes input image bytes, stalls on command
// assumes the bench picks the stall pattern each cycle
`timescale 1ns/10ps
`default_nettype none
module diam_client
(
    input  wire logic        core_clk,
    input  wire logic [7:0]  tx_data,
    input  wire logic        tx_valid,
    input  wire logic        stall,
    output var  logic        tx_ready,
    output var  logic [31:0] got,
    output var  logic [7:0]  got_n
);
    // ------------------------------------------------
    // sink: newest byte enters at the top
    // ------------------------------------------------
    initial
    begin
        tx_ready = 1'b0;
        got = 32'h0000_0000;
        got_n = 8'h00;
    end
    // byte 0 ends up lowest, so got reads {b3,b2,b1,b0}
    always @(posedge core_clk)
    begin
        if (tx_valid && tx_ready)
        begin
            got <= {tx_data, got[31:8]};
            got_n <= got_n + 8'h01;
        end
        tx_ready <= !stall;
    end
endmodule
`default_nettype wire

//--- test/tb_top.sv
// bench for the image mapper: random images in, status images out
// assumes core/diam_map.vh on the include path
`timescale 1ns/10ps
`default_nettype none
`include "diam_map.vh"
`define CHK(a, b) begin compares = compares + 1; if ((a) !== (b)) begin \
 fail_count = fail_count + 1; \
 $display("wrong value at %0t: %h %h", $time, a, b); end end
module tb_top;
    logic core_clk, sys_rst, rx_valid, rx_first, rx_conn, rx_ready;
    logic run, frst, rev, upd, conn, err, flt, rfw, req, busy;
    logic tval, tlast, trdy, stall, seen;
    logic [7:0] rx_data, rx_image, tdat, gn;
    logic [15:0] spd, act;
    logic [31:0] got, rnd, srnd;
    logic [159:0] par, exp_par;
    logic [7:0] buf_b [0:23];
    integer fail_count, compares, it, i, k;
    diam_mapper u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_first(rx_first),
        .rx_image(rx_image), .rx_conn(rx_conn), .rx_ready(rx_ready),
        .cmd_run_fwd_ff(run), .cmd_fault_rst_ff(frst),
        .cmd_speed_ref_ff(spd), .cmd_reverse_ff(rev), .cmd_param_ff(par),
        .cmd_update_ff(upd), .cmd_conn_ff(conn), .rx_error_ff(err),
        .sts_faulted(flt), .sts_running_fwd(rfw), .sts_speed_act(act),
        .tx_req(req), .tx_busy(busy), .tx_data(tdat), .tx_valid(tval),
        .tx_last(tlast), .tx_ready(trdy));
    diam_client u_cli (.core_clk(core_clk), .tx_data(tdat), .tx_valid(tval),
        .stall(stall), .tx_ready(trdy), .got(got), .got_n(gn));
    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    function automatic [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task end_of_test;
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // drives a whole image, byte held until taken
    task send(input [7:0] img, input c, input integer n);
        seen = 1'b0;
        for (i = 0; i < n; i = i + 1)
        begin
            rx_data <= buf_b[i];
            rx_valid <= 1'b1;
            rx_first <= (i == 0);
            rx_image <= img;
            rx_conn <= c;
            @(posedge core_clk);
            seen = seen | (err === 1'b1);
            while (rx_ready !== 1'b1) @(posedge core_clk);
        end
        rx_valid <= 1'b0;
        rx_first <= 1'b0;
        // error pulse may come and go while later bytes still go in
        for (k = 0; k < 20 && upd !== 1'b1 && !seen; k = k + 1)
        begin
            @(posedge core_clk);
            seen = seen | (err === 1'b1);
        end
    endtask
    // ------------------------------------------------
    // clock, watchdog, stall pattern
    // ------------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial
    begin
        #800000;
        fail_count = fail_count + 1;
        end_of_test;
    end
    // own generator, so stalls keep moving while the main sequence waits
    always @(posedge core_clk)
    begin
        if (sys_rst)
            srnd <= 32'h0001_60db;
        else
            srnd <= lfsr(srnd);
        stall <= !sys_rst && srnd[3] && srnd[7];
    end
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial
    begin
        {sys_rst, rx_valid, rx_first, rx_conn, req, flt, rfw} = 7'h40;
        {rx_data, rx_image, act} = 32'h0000_0000;
        rnd = 32'h0001_60db;
        fail_count = 0;
        compares = 0;
        exp_par = 160'h0;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        `CHK({run, frst, spd, par, upd, tval}, 180'h0)
        for (it = 0; it < 12; it = it + 1)
        begin
            for (i = 0; i < 24; i = i + 1)
            begin
                rnd = lfsr(rnd);
                buf_b[i] = rnd[7:0];
            end
            if (it == 0)
                {buf_b[3], buf_b[2]} = 16'h8000;
            send((it % 3 == 1) ? `DIAM_IMG_OUT_PARAM : `DIAM_IMG_OUT_BASIC,
                rnd[9], (it % 3 == 1) ? 24 : 4);
            `CHK(seen, 1'b0)
            if (it % 3 == 1)
                for (i = 0; i < 10; i = i + 1)
                    exp_par[16*i +: 16] = {buf_b[5+2*i], buf_b[4+2*i]};
            `CHK({run, frst}, {buf_b[0][0], buf_b[0][2]})
            `CHK(spd, {buf_b[3], buf_b[2]})
            `CHK(rev, buf_b[3][7])
            `CHK(par, exp_par)
            `CHK(conn, rnd[9])
            buf_b[0] = 8'hff;
            send(8'h15, 1'b0, 4);
            `CHK(seen, 1'b1)
            `CHK(spd, {buf_b[3], buf_b[2]})
            {flt, rfw, act} <= {rnd[12:11], rnd[31:16]};
            req <= 1'b1;
            k = gn + 4;
            @(posedge core_clk);
            req <= 1'b0;
            for (i = 0; i < 60 && gn != k[7:0]; i = i + 1)
                @(posedge core_clk);
            `CHK(got, {rnd[31:16], 13'h0, rnd[11], 1'b0, rnd[12]})
            $display("test %0d done", it);
        end
        end_of_test;
    end
endmodule
`default_nettype wire
